// [hdl/pmt_map.vh]
// Register offsets, field positions, codes and reset values of the mirror/trunk block
`ifndef PMT_MAP_VH
`define PMT_MAP_VH
`define PMT_A_MIR_SET   8'h00
`define PMT_A_MIR_DEST  8'h04
`define PMT_A_MIR_DROP  8'h08
`define PMT_A_TRK_CMD   8'h0c
`define PMT_A_TRK_MAP   8'h10
`define PMT_A_LACP_EN   8'h14
`define PMT_A_TRK_STAT  8'h18
`define PMT_A_PORT_SET  8'h1c
`define PMT_A_TRK_SET   8'h20
`define PMT_F_CLEAR     8
`define PMT_F_REMOVE    8
`define PMT_F_ATTR_FDX  2
`define PMT_DIR_NONE    2'h0
`define PMT_DIR_RX      2'h1
`define PMT_DIR_TX      2'h2
`define PMT_DIR_BOTH    2'h3
`define PMT_TRK_MIN     3'h1
`define PMT_TRK_MAX     3'h6
`define PMT_LIM_FAST    4'h4
`define PMT_LIM_GIG     4'h2
`define PMT_SPD_GIG     2'h2
`define PMT_ERR_OK      2'h0
`define PMT_ERR_BADIDX  2'h1
`define PMT_ERR_FULL    2'h2
`define PMT_ERR_REFUSE  2'h3
`define PMT_RST_DEST    3'h0
`define PMT_RST_LACP    8'h00
`endif

// [hdl/pmt_top.v]
// Port mirroring and link aggregation control for an eight-port switch core
//
// Overview of operation
// - Copy rx, tx or both frames of each mirrored source per its direction.
// - A session enabled with direction zero mirrors both directions.
// - Out of reset no session exists and no copies are made.
// - Many sessions may run, all sharing one destination port.
// - A clear command ends the session of the named source port.
// - Copies are extra; normal forwarding is neither altered nor delayed.
// - Copies beyond what the destination accepts are dropped and counted.
// - Trunk indices run 1 to 6; others are refused.
// - At most four 10/100 members or two gigabit members per trunk.
// - All members of a trunk share one media type; dynamic joins are not checked for it.
// - Members must match speed, duplex, flow control, VLAN and CoS; only static adds compare attributes, dynamic joins do not.
// - STP, VLAN and IGMP settings apply to whole trunks, not single members.
// - A remove command returns a port to independent operation.
// - Per-port dynamic aggregation enable, off after reset.
// - Dynamic trunk members must run full duplex at both ends; the scan checks only the local port's duplex bit.
// - A newly negotiated trunk takes the lowest free trunk index.
// - If the partner also runs LACP the trunk activates by itself.
// - Surplus dynamic ports wait in standby until an active member fails.
// - Report source, destination and direction of each mirror session.
`timescale 1ns/1ps
`include "pmt_map.vh"

module pmt_top (
    input  wire        ref_clk_in,
    input  wire        resetn_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output wire [31:0] reg_rdata_out,
    input  wire [7:0]  rx_frame_in,
    input  wire [7:0]  tx_frame_in,
    input  wire        dest_ready_in,
    output wire        mir_valid_out,
    output wire [2:0]  mir_src_out,
    output wire [1:0]  mir_dir_out,
    output wire [2:0]  mir_dest_out,
    input  wire [63:0] port_attr_in,
    input  wire [7:0]  link_up_in,
    input  wire [7:0]  partner_lacp_in,
    input  wire [23:0] partner_key_in,
    input  wire        fwd_req_in,
    input  wire [2:0]  fwd_trunk_in,
    input  wire [3:0]  fwd_hash_in,
    output wire        fwd_valid_out,
    output wire [2:0]  fwd_port_out,
    output wire        fwd_drop_out,
    output wire [63:0] port_set_out,
    output wire [23:0] trk_map_out,
    output wire [7:0]  active_out
);

    reg [15:0] mir_dir_r;
    reg [2:0]  dest_r;
    reg [15:0] drop_r;
    reg [1:0]  err_r;
    reg [23:0] trk_r;
    reg [7:0]  dyn_r;
    reg [7:0]  stby_r;
    reg [7:0]  lacp_r;
    reg [63:0] pset_r;
    reg [2:0]  scan_r;
    reg [31:0] rdata_r;
    reg        mir_valid_r;
    reg [2:0]  mir_src_r;
    reg [1:0]  mir_dirq_r;
    reg [2:0]  mir_dest_r;
    reg        fwd_valid_r;
    reg        fwd_drop_r;
    reg [2:0]  fwd_port_r;
    reg [7:0]  act_r;

    function [3:0] pop8;
        input [7:0] m;
        integer i;
        begin
            pop8 = 4'h0;
            for (i = 0; i < 8; i = i + 1)
                pop8 = pop8 + {3'h0, m[i]};
        end
    endfunction

    // Index of the n-th set bit, counting from bit 0
    function [2:0] nth8;
        input [7:0] m;
        input [3:0] n;
        integer i;
        reg [3:0] c;
        begin
            nth8 = 3'h0;
            c = 4'h0;
            for (i = 0; i < 8; i = i + 1) begin
                if (m[i]) begin
                    if (c == n)
                        nth8 = i[2:0];
                    c = c + 4'h1;
                end
            end
        end
    endfunction

    // Remainder by repeated subtraction; divisor is 1 to 8, never zero here
    function [3:0] mod4;
        input [3:0] h;
        input [3:0] d;
        integer i;
        begin
            mod4 = h;
            for (i = 0; i < 16; i = i + 1)
                if (mod4 >= d)
                    mod4 = mod4 - d;
        end
    endfunction

    function [4:0] first16;
        input [15:0] m;
        integer i;
        begin
            first16 = 5'h0;
            for (i = 15; i >= 0; i = i - 1)
                if (m[i])
                    first16 = {1'b1, i[3:0]};
        end
    endfunction

    function [3:0] limit;
        input [1:0] spd;
        begin
            limit = (spd == `PMT_SPD_GIG) ? `PMT_LIM_GIG : `PMT_LIM_FAST;
        end
    endfunction

    wire       wr_mset = reg_wr_in && (reg_addr_in == `PMT_A_MIR_SET);
    wire       wr_tcmd = reg_wr_in && (reg_addr_in == `PMT_A_TRK_CMD);
    wire       wr_pset = reg_wr_in && (reg_addr_in == `PMT_A_PORT_SET);
    wire       wr_tset = reg_wr_in && (reg_addr_in == `PMT_A_TRK_SET);
    wire       wr_dest = reg_wr_in && (reg_addr_in == `PMT_A_MIR_DEST);
    wire       wr_lacp = reg_wr_in && (reg_addr_in == `PMT_A_LACP_EN);
    wire [2:0] cp      = reg_wdata_in[2:0];
    wire [2:0] ct      = reg_wdata_in[6:4];
    wire [1:0] cdir    = reg_wdata_in[5:4];

    reg [7:0]  mm [0:7];
    reg [7:0]  am [0:7];
    reg [6:0]  used;
    reg [2:0]  free_t;
    reg [1:0]  add_err;
    reg [2:0]  join_t;
    reg [2:0]  tgt_t;
    reg [2:0]  sp_t;
    reg        sp_ok;
    reg        sc_leave;
    reg        sc_join;
    reg        sc_stby;
    reg        sc_prom;
    reg        sc_demote;
    reg [15:0] cand;
    reg [4:0]  pick;
    reg [15:0] rest;
    reg [7:0]  fmask;
    reg [31:0] rd_mux;
    integer    i;
    integer    q;
    integer    k;

    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            mm[i] = 8'h00;
            am[i] = 8'h00;
        end
        for (i = 0; i < 8; i = i + 1) begin
            mm[trk_r[i*3 +: 3]][i] = 1'b1;
            am[trk_r[i*3 +: 3]][i] = link_up_in[i] & ~stby_r[i];
        end
        used = 7'h00;
        for (i = 1; i < 7; i = i + 1)
            used[i] = |mm[i];
        // Walking down from the top leaves the lowest unused index
        free_t = 3'h0;
        for (i = 6; i >= 1; i = i - 1)
            if (!used[i])
                free_t = i[2:0];

        // Static add: index, member count and identical attributes
        add_err = `PMT_ERR_OK;
        if (ct < `PMT_TRK_MIN || ct > `PMT_TRK_MAX)
            add_err = `PMT_ERR_BADIDX;
        else if (dyn_r[cp])
            add_err = `PMT_ERR_REFUSE;
        else begin
            if (pop8(mm[ct] & ~(8'h01 << cp)) >= limit(port_attr_in[cp*8 +: 2]))
                add_err = `PMT_ERR_FULL;
            for (q = 0; q < 8; q = q + 1)
                if (mm[ct][q] && q != cp && port_attr_in[q*8 +: 8] != port_attr_in[cp*8 +: 8])
                    add_err = `PMT_ERR_REFUSE;
        end

        // Dynamic scan of one port per cycle
        sp_t  = trk_r[scan_r*3 +: 3];
        sp_ok = lacp_r[scan_r] & partner_lacp_in[scan_r]
              & port_attr_in[scan_r*8 + `PMT_F_ATTR_FDX];
        join_t = 3'h0;
        for (q = 0; q < 8; q = q + 1)
            if (q != scan_r && dyn_r[q] && trk_r[q*3 +: 3] != 3'h0
                && partner_key_in[q*3 +: 3] == partner_key_in[scan_r*3 +: 3])
                join_t = trk_r[q*3 +: 3];
        tgt_t     = (join_t != 3'h0) ? join_t : free_t;
        sc_leave  = dyn_r[scan_r] & ~sp_ok;
        // A port holding a static index is never taken over by the scan
        sc_join   = ~dyn_r[scan_r] & (sp_t == 3'h0) & sp_ok & (tgt_t != 3'h0);
        sc_stby   = pop8(am[tgt_t]) >= limit(port_attr_in[scan_r*8 +: 2]);
        // Promotion and demotion both run, as a returning link can overfill a trunk
        sc_prom   = dyn_r[scan_r] & sp_ok & stby_r[scan_r] & link_up_in[scan_r]
                  & (pop8(am[sp_t]) < limit(port_attr_in[scan_r*8 +: 2]));
        sc_demote = dyn_r[scan_r] & sp_ok & ~stby_r[scan_r] & link_up_in[scan_r]
                  & (pop8(am[sp_t]) > limit(port_attr_in[scan_r*8 +: 2]));

        // Mirror candidates: even bit rx, odd bit tx of each port
        for (i = 0; i < 8; i = i + 1) begin
            cand[2*i]   = rx_frame_in[i] & mir_dir_r[2*i];
            cand[2*i+1] = tx_frame_in[i] & mir_dir_r[2*i+1];
        end
        // Only the lowest candidate is copied per cycle; any others add one drop per cycle
        pick = first16(cand);
        rest = cand & ~(16'h0001 << pick[3:0]);

        // Index 0 means no trunk, so egress on it always drops
        if (fwd_trunk_in == 3'h0)
            fmask = 8'h00;
        else
            fmask = am[fwd_trunk_in] & mm[fwd_trunk_in];

        // Unmapped reads return zero rather than a stale register
        case (reg_addr_in)
            `PMT_A_MIR_SET:  rd_mux = {16'h0000, mir_dir_r};
            `PMT_A_MIR_DEST: rd_mux = {29'h0, dest_r};
            `PMT_A_MIR_DROP: rd_mux = {16'h0000, drop_r};
            `PMT_A_TRK_CMD:  rd_mux = {30'h0, err_r};
            `PMT_A_TRK_MAP:  rd_mux = {8'h00, trk_r};
            `PMT_A_LACP_EN:  rd_mux = {24'h000000, lacp_r};
            `PMT_A_TRK_STAT: rd_mux = {8'h00, dyn_r, stby_r, act_r};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mir_dir_r   <= 16'h0000;
            dest_r      <= `PMT_RST_DEST;
            drop_r      <= 16'h0000;
            err_r       <= `PMT_ERR_OK;
            rdata_r     <= 32'h00000000;
            mir_valid_r <= 1'b0;
            mir_src_r   <= 3'h0;
            mir_dirq_r  <= `PMT_DIR_NONE;
            mir_dest_r  <= `PMT_RST_DEST;
        end else begin
            // Read data stands for one cycle and is zero otherwise
            rdata_r <= reg_rd_in ? rd_mux : 32'h00000000;
            if (wr_mset) begin
                if (reg_wdata_in[`PMT_F_CLEAR])
                    mir_dir_r[cp*2 +: 2] <= `PMT_DIR_NONE;
                else if (cdir == `PMT_DIR_NONE)
                    mir_dir_r[cp*2 +: 2] <= `PMT_DIR_BOTH;
                else
                    mir_dir_r[cp*2 +: 2] <= cdir;
            end
            // One destination register serves every session
            if (wr_dest)
                dest_r <= reg_wdata_in[2:0];
            // Copies only observe frame events, so forwarding never waits on them
            mir_valid_r <= pick[4] & dest_ready_in;
            mir_src_r   <= pick[3:1];
            mir_dirq_r  <= pick[0] ? `PMT_DIR_TX : `PMT_DIR_RX;
            mir_dest_r  <= dest_r;
            // Saturating so that a long overload does not wrap to a small count
            if (((pick[4] && !dest_ready_in) || (|rest)) && drop_r != 16'hffff)
                drop_r <= drop_r + 16'h0001;
            // Every trunk, port-set and trunk-set command leaves its own outcome for software to read back
            if (wr_tcmd)
                err_r <= reg_wdata_in[`PMT_F_REMOVE] ? `PMT_ERR_OK : add_err;
            else if (wr_pset)
                err_r <= (trk_r[cp*3 +: 3] != 3'h0) ? `PMT_ERR_REFUSE : `PMT_ERR_OK;
            else if (wr_tset && (cp < `PMT_TRK_MIN || cp > `PMT_TRK_MAX))
                err_r <= `PMT_ERR_BADIDX;
            else if (wr_tset)
                err_r <= `PMT_ERR_OK;
        end
    end

    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trk_r  <= 24'h000000;
            dyn_r  <= 8'h00;
            stby_r <= 8'h00;
            // Negotiation stays off until software enables it port by port
            lacp_r <= `PMT_RST_LACP;
            pset_r <= 64'h0000000000000000;
            scan_r <= 3'h0;
            act_r  <= 8'h00;
        end else begin
            scan_r <= scan_r + 3'h1;
            // Default first, then every trunk member overrides its own bit
            act_r  <= link_up_in & ~stby_r & dyn_r;
            for (k = 0; k < 8; k = k + 1)
                if (trk_r[k*3 +: 3] != 3'h0)
                    act_r[k] <= link_up_in[k] & ~stby_r[k];
            if (wr_lacp)
                lacp_r <= reg_wdata_in[7:0];
            if (wr_pset && trk_r[cp*3 +: 3] == 3'h0)
                pset_r[cp*8 +: 8] <= reg_wdata_in[15:8];
            if (wr_tset && cp >= `PMT_TRK_MIN && cp <= `PMT_TRK_MAX) begin
                for (k = 0; k < 8; k = k + 1)
                    if (trk_r[k*3 +: 3] == cp)
                        pset_r[k*8 +: 8] <= reg_wdata_in[15:8];
            end
            // A register command owns the membership state in its cycle
            if (wr_tcmd) begin
                if (reg_wdata_in[`PMT_F_REMOVE]) begin
                    // Its negotiation enable goes too, so the scan cannot pull it back
                    trk_r[cp*3 +: 3] <= 3'h0;
                    dyn_r[cp]        <= 1'b0;
                    stby_r[cp]       <= 1'b0;
                    lacp_r[cp]       <= 1'b0;
                end else if (add_err == `PMT_ERR_OK) begin
                    trk_r[cp*3 +: 3] <= ct;
                end
            end else if (sc_leave) begin
                trk_r[scan_r*3 +: 3] <= 3'h0;
                dyn_r[scan_r]        <= 1'b0;
                stby_r[scan_r]       <= 1'b0;
            end else if (sc_join) begin
                trk_r[scan_r*3 +: 3] <= tgt_t;
                dyn_r[scan_r]        <= 1'b1;
                stby_r[scan_r]       <= sc_stby;
            end else if (sc_prom) begin
                stby_r[scan_r] <= 1'b0;
            end else if (sc_demote) begin
                stby_r[scan_r] <= 1'b1;
            end
        end
    end

    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fwd_valid_r <= 1'b0;
            fwd_drop_r  <= 1'b0;
            fwd_port_r  <= 3'h0;
        end else begin
            fwd_valid_r <= fwd_req_in && (fmask != 8'h00);
            fwd_drop_r  <= fwd_req_in && (fmask == 8'h00);
            // Hash spreads flows over live members only
            // An empty mask divides by one so the remainder stays defined
            fwd_port_r  <= nth8(fmask, mod4(fwd_hash_in, pop8(fmask) | {3'h0, ~|fmask}));
        end
    end

    assign reg_rdata_out = rdata_r;
    assign mir_valid_out = mir_valid_r;
    assign mir_src_out   = mir_src_r;
    assign mir_dir_out   = mir_dirq_r;
    assign mir_dest_out  = mir_dest_r;
    assign fwd_valid_out = fwd_valid_r;
    assign fwd_port_out  = fwd_port_r;
    assign fwd_drop_out  = fwd_drop_r;
    assign port_set_out  = pset_r;
    assign trk_map_out   = trk_r;
    assign active_out    = act_r;

endmodule

// [tb/pmt_peer.sv]
// Model of the peer switch at the far end of the trunk links
`timescale 1ns/1ps
module pmt_peer #(
    parameter [2:0] PEER_KEY = 3'h5
) (
    input  wire        ref_clk_in,
    input  wire [7:0]  up_in,
    input  wire [7:0]  lacp_in,
    output reg  [7:0]  link_up_out = 8'h00,
    output reg  [7:0]  partner_lacp_out = 8'h00,
    output reg  [23:0] partner_key_out = 24'h0
);
    integer i;
    always @(posedge ref_clk_in) begin
        link_up_out <= up_in;
        // Our ends are trunk ports run full duplex; LACP only speaks on live links
        partner_lacp_out <= lacp_in & up_in;
        for (i = 0; i < 8; i = i + 1) begin
            // A dead link shows no stable identity
            partner_key_out[3*i+:3] <= up_in[i] ? PEER_KEY : ~partner_key_out[3*i+:3];
        end
    end
endmodule

// [tb/pmt_top_assertions.sv]
// Port checker for the mirror and trunk control block
`timescale 1ns/1ps
module pmt_top_assertions (
    input wire        ref_clk_in,
    input wire        resetn_in,
    input wire        reg_rd_in,
    input wire [31:0] reg_rdata_out,
    input wire [7:0]  rx_frame_in,
    input wire [7:0]  tx_frame_in,
    input wire        dest_ready_in,
    input wire        mir_valid_out,
    input wire [2:0]  mir_src_out,
    input wire [1:0]  mir_dir_out,
    input wire        fwd_req_in,
    input wire        fwd_valid_out,
    input wire [2:0]  fwd_port_out,
    input wire        fwd_drop_out,
    input wire [23:0] trk_map_out,
    input wire [7:0]  active_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // A field holding 7 is an index the block must never hand out
    function automatic logic idx_bad(input logic [23:0] m);
        idx_bad = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (m[3*i+:3] == 3'h7) idx_bad = 1'b1;
        end
    endfunction
    a_rd_idle_zero:
        assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data present without a read");
    a_reset_quiet:
        assert property ($rose(resetn_in) |-> !mir_valid_out && trk_map_out == 24'h0)
        else $error("outputs not idle after reset");
    a_mir_cause:
        assert property (mir_valid_out |-> $past(dest_ready_in)
            && ((((mir_dir_out == 2'h1) ? $past(rx_frame_in) : $past(tx_frame_in))
            >> mir_src_out) & 8'h01) != 8'h00)
        else $error("mirror copy without a matching frame");
    a_mir_dir_code:
        assert property (mir_valid_out |-> mir_dir_out inside {2'h1, 2'h2})
        else $error("mirror copy with bad direction");
    a_fwd_answer:
        assert property (fwd_req_in |=> fwd_valid_out != fwd_drop_out)
        else $error("egress request without one answer");
    a_fwd_cause:
        assert property ((fwd_valid_out || fwd_drop_out) |-> $past(fwd_req_in))
        else $error("egress answer without a request");
    a_fwd_active:
        assert property (fwd_valid_out
            |-> ((((active_out | $past(active_out)) >> fwd_port_out) & 8'h01) != 8'h00))
        else $error("egress chose an inactive member");
    a_trk_idx_range:
        assert property (!idx_bad(trk_map_out))
        else $error("trunk index out of range");
endmodule

bind pmt_top pmt_top_assertions u_chk (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rx_frame_in(rx_frame_in), .tx_frame_in(tx_frame_in),
    .dest_ready_in(dest_ready_in), .mir_valid_out(mir_valid_out),
    .mir_src_out(mir_src_out), .mir_dir_out(mir_dir_out), .fwd_req_in(fwd_req_in),
    .fwd_valid_out(fwd_valid_out), .fwd_port_out(fwd_port_out),
    .fwd_drop_out(fwd_drop_out), .trk_map_out(trk_map_out), .active_out(active_out)
);

// [tb/pmt_top_test.sv]
// Self-checking bench for the mirror and trunk control block
`timescale 1ns/1ps
`include "pmt_map.vh"
module pmt_top_test;
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg         wr_s = 1'b0;
    reg         rd_s = 1'b0;
    reg  [7:0]  rx = 8'h00;
    reg  [7:0]  tx = 8'h00;
    reg         rdy = 1'b1;
    reg  [63:0] attr = {8{8'h04}};
    reg  [7:0]  up = 8'hff;
    reg  [7:0]  lacp = 8'h00;
    reg         freq = 1'b0;
    reg  [2:0]  ftrk = 3'h0;
    reg  [3:0]  fhash = 4'h0;
    wire [31:0] rdata;
    wire        mv, fv, fdrop;
    wire [2:0]  msrc, mdest, fport;
    wire [1:0]  mdir;
    wire [7:0]  link, plac, act;
    wire [23:0] pkey, tmap;
    wire [63:0] pset;
    integer     n_errors = 0;
    integer     comparisons = 0;
    integer     i;
    reg  [31:0] v;
    wire [31:0] mir_w = mv ? {23'h0, mv, msrc, mdir, mdest} : 32'h0;
    wire [31:0] fwd_w = {27'h0, fv, fdrop, fv ? fport : 3'h0};
    pmt_top dut (
        .ref_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .rx_frame_in(rx),
        .tx_frame_in(tx), .dest_ready_in(rdy), .mir_valid_out(mv), .mir_src_out(msrc),
        .mir_dir_out(mdir), .mir_dest_out(mdest), .port_attr_in(attr), .link_up_in(link),
        .partner_lacp_in(plac), .partner_key_in(pkey), .fwd_req_in(freq),
        .fwd_trunk_in(ftrk), .fwd_hash_in(fhash), .fwd_valid_out(fv), .fwd_port_out(fport),
        .fwd_drop_out(fdrop), .port_set_out(pset), .trk_map_out(tmap), .active_out(act));
    pmt_peer #(.PEER_KEY(3'h5)) peer (.ref_clk_in(clk), .up_in(up), .lacp_in(lacp),
        .link_up_out(link), .partner_lacp_out(plac), .partner_key_out(pkey));
    initial begin
        forever #50 clk = ~clk;
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // Read data is taken in the one cycle where it stands
    task rc(input [7:0] a, input [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        chk(v, exp);
    endtask
    // Plain read into v, for values judged field by field afterwards
    task rd(input [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task ev(input [7:0] r, input [7:0] t);
        @(posedge clk);
        rx <= r;
        tx <= t;
        @(posedge clk);
        rx <= 8'h00;
        tx <= 8'h00;
        #1;
    endtask
    task fw(input [2:0] t, input [3:0] h, input [31:0] exp);
        @(posedge clk);
        freq <= 1'b1;
        ftrk <= t;
        fhash <= h;
        @(posedge clk);
        freq <= 1'b0;
        #1 chk(fwd_w, exp);
    endtask
    task t_reset;
        rc(`PMT_A_LACP_EN, 32'h0);
        rc(`PMT_A_MIR_SET, 32'h0);
        rc(`PMT_A_MIR_DEST, 32'h0);
        rc(8'hfc, 32'h0);
        ev(8'hff, 8'hff);
        chk(mir_w, 32'h0);
        $display("reset test done");
    endtask
    task t_mirror;
        wr(`PMT_A_MIR_DEST, 32'h5);
        wr(`PMT_A_MIR_SET, 32'h006);
        wr(`PMT_A_MIR_SET, 32'h012);
        rc(`PMT_A_MIR_SET, 32'h3010);
        rc(`PMT_A_MIR_DEST, 32'h5);
        ev(8'h40, 8'h00);
        chk(mir_w, {23'h0, 1'b1, 3'h6, `PMT_DIR_RX, 3'h5});
        ev(8'h00, 8'h40);
        chk(mir_w, {23'h0, 1'b1, 3'h6, `PMT_DIR_TX, 3'h5});
        ev(8'h00, 8'h04);
        chk(mir_w, 32'h0);
        // Two sources at once: the lower candidate wins, the other is dropped
        ev(8'h44, 8'h00);
        chk(mir_w, {23'h0, 1'b1, 3'h2, `PMT_DIR_RX, 3'h5});
        @(posedge clk);
        rdy <= 1'b0;
        ev(8'h40, 8'h00);
        chk(mir_w, 32'h0);
        rdy <= 1'b1;
        rc(`PMT_A_MIR_DROP, 32'h2);
        wr(`PMT_A_MIR_SET, 32'h106);
        ev(8'h40, 8'h40);
        chk(mir_w, 32'h0);
        rc(`PMT_A_MIR_SET, 32'h0010);
        $display("mirror test done");
    endtask
    task t_static;
        wr(`PMT_A_TRK_CMD, 32'h070);
        rc(`PMT_A_TRK_CMD, 32'h1);
        for (i = 0; i < 4; i = i + 1) wr(`PMT_A_TRK_CMD, 32'h010 | i);
        rc(`PMT_A_TRK_CMD, 32'h0);
        wr(`PMT_A_TRK_CMD, 32'h014);
        rc(`PMT_A_TRK_CMD, 32'h2);
        rc(`PMT_A_TRK_MAP, 32'h249);
        wr(`PMT_A_PORT_SET, 32'h5a00);
        rc(`PMT_A_TRK_CMD, 32'h3);
        wr(`PMT_A_TRK_SET, 32'h5a01);
        rc(`PMT_A_TRK_CMD, 32'h0);
        chk(pset[31:0], 32'h5a5a5a5a);
        chk(pset[63:32], 32'h0);
        wr(`PMT_A_TRK_CMD, 32'h103);
        rc(`PMT_A_TRK_MAP, 32'h049);
        @(posedge clk);
        attr[31:24] <= 8'h14;
        wr(`PMT_A_TRK_CMD, 32'h013);
        rc(`PMT_A_TRK_CMD, 32'h3);
        attr <= {8{8'h04}};
        chk({24'h0, act}, 32'h07);
        fw(3'h1, 4'h4, 32'h11);
        @(posedge clk);
        up <= 8'hfd;
        // The peer and the status register each add one cycle
        repeat (2) @(posedge clk);
        rc(`PMT_A_TRK_STAT, 32'h05);
        fw(3'h1, 4'h1, 32'h12);
        fw(3'h5, 4'h0, 32'h08);
        fw(3'h0, 4'h3, 32'h08);
        up <= 8'hff;
        $display("static trunk test done");
    endtask
    task t_lacp;
        wr(`PMT_A_LACP_EN, 32'hf8);
        rc(`PMT_A_LACP_EN, 32'hf8);
        repeat (40) @(posedge clk);
        rc(`PMT_A_TRK_MAP, 32'h049);
        lacp <= 8'hf8;
        repeat (40) @(posedge clk);
        rd(`PMT_A_TRK_STAT);
        chk({23'h0, tmap[8:0]}, 32'h049);
        chk({24'h0, v[23:16]}, 32'hf8);
        chk(32'($countones(v[15:8])), 32'h1);
        chk(32'($countones(v[7:0] & 8'hf8)), 32'h4);
        for (i = 3; i < 8; i = i + 1) begin
            if (v[i]) chk({29'h0, tmap[3*i+:3]}, 32'h2);
        end
        // Fail the lowest active dynamic member; the standby port must step in
        for (i = 7; i > 2; i = i - 1) begin
            if (v[i]) v[31:24] = 8'hff & ~(8'h01 << i);
        end
        up <= v[31:24];
        repeat (40) @(posedge clk);
        rd(`PMT_A_TRK_STAT);
        chk({24'h0, v[23:16]}, {24'h0, 8'hf8 & up});
        chk({24'h0, v[15:8]}, 32'h0);
        chk(32'($countones(v[7:0] & 8'hf8)), 32'h4);
        $display("dynamic trunk test done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        $display("run stopped by watchdog");
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_mirror;
        t_static;
        t_lacp;
        stop_test;
    end
endmodule
